// ==== inc/fpio_regs.svh ====
/*
  Register offsets, field positions and reset values for the four-port I/O
  block. Assumes it is included by bare name with the inc folder on the path.
*/
`ifndef FPIO_REGS_SVH
`define FPIO_REGS_SVH

`define FPIO_ADDR_PORTA    8'h00
`define FPIO_ADDR_PORTB    8'h01
`define FPIO_ADDR_PORTC    8'h02
`define FPIO_ADDR_PORTD    8'h03
`define FPIO_ADDR_DIRA     8'h04
`define FPIO_ADDR_DIRB     8'h05
`define FPIO_ADDR_DIRC     8'h06
`define FPIO_ADDR_CLKCTL   8'h07
`define FPIO_ADDR_ADCTL    8'h09
`define FPIO_CLKOUT_BIT    3
`define FPIO_CONV_ON_BIT   5
`define FPIO_CLK_PIN       2
`define FPIO_CLKCTL_MASK   8'h0f
`define FPIO_ADCTL_MASK    8'hef
`define FPIO_RST_BYTE      8'h00
`define FPIO_LATCH_INIT    8'h00

`endif

// ==== inc/fpio_pkg.sv ====
/*
  Types shared by the four-port I/O block.
  Assumes nothing of its surroundings.
*/
package fpio_pkg;
  typedef logic [7:0] fpio_byte_type;
endpackage : fpio_pkg

// ==== rtl/fpio_pin_slice.sv ====
/*
  One bidirectional eight-bit port: output latch, direction register,
  effective direction and read-back selection.
  Assumes synchronous pin inputs and a plain one-cycle register bus.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpio_regs.svh"

module fpio_pin_slice
  import fpio_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             data_wr_in,
  input  wire logic             dir_wr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  input  wire logic [WIDTH-1:0] force_dir_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] latch_out,
  output logic      [WIDTH-1:0] dir_out,
  output logic      [WIDTH-1:0] eff_dir_out,
  output logic      [WIDTH-1:0] rd_data_out
);
  // ************************************************************
  // Latch and direction state
  // ************************************************************
  logic [WIDTH-1:0] latch_ff;
  logic [WIDTH-1:0] nxt_latch;
  logic [WIDTH-1:0] dir_ff;
  logic [WIDTH-1:0] nxt_dir;

  // Next values of the latch and the direction register.
  always_comb
  begin
    nxt_latch = latch_ff;
    nxt_dir   = dir_ff;
    if (data_wr_in)
    begin
      nxt_latch = wdata_in;
    end
    if (dir_wr_in)
    begin
      nxt_dir = wdata_in;
    end
  end

  // The latch has no reset: reset leaves its contents as they were.
  always_ff @(posedge sys_clk_in)
  begin
    latch_ff <= nxt_latch;
  end

  // Direction clears on reset so every pin starts as an input.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      dir_ff <= `FPIO_RST_BYTE;
    else
      dir_ff <= nxt_dir;
  end

  // Read-back picks the latch for outputs and the pin for inputs.
  wire [WIDTH-1:0] eff_dir_w;
  wire [WIDTH-1:0] rd_data_w;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign eff_dir_w[i] = dir_ff[i] | force_dir_in[i];
      assign rd_data_w[i] = eff_dir_w[i] ? latch_ff[i] : pin_in[i];
    end
  endgenerate

  assign latch_out   = latch_ff;
  assign dir_out     = dir_ff;
  assign eff_dir_out = eff_dir_w;
  assign rd_data_out = rd_data_w;
endmodule : fpio_pin_slice
`default_nettype wire

// ==== rtl/fpio_top.sv ====
/*
  Four-port general-purpose I/O with a clock output on port C pin two.
  Assumes a single 200 MHz clock, pin inputs synchronous to it, and a
  plain register port with read data one cycle after the read strobe.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "fpio_regs.svh"

module fpio_top
  import fpio_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int CLK_DIV = 2
)
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire fpio_pkg::fpio_byte_type addr_in,
  input  wire fpio_pkg::fpio_byte_type wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output var fpio_pkg::fpio_byte_type rdata_out,
  input  wire logic [WIDTH-1:0]     port_a_pin_in,
  output logic      [WIDTH-1:0]     port_a_pin_out,
  output logic      [WIDTH-1:0]     port_a_pin_oe_n_out,
  input  wire logic [WIDTH-1:0]     port_b_pin_in,
  output logic      [WIDTH-1:0]     port_b_pin_out,
  output logic      [WIDTH-1:0]     port_b_pin_oe_n_out,
  input  wire logic [WIDTH-1:0]     port_c_pin_in,
  output logic      [WIDTH-1:0]     port_c_pin_out,
  output logic      [WIDTH-1:0]     port_c_pin_oe_n_out,
  input  wire logic [WIDTH-1:0]     shared_input_pins_in,
  output logic                      converter_on_out,
  output logic                      internal_phase_clock_out
);
  // ************************************************************
  // Register strobes
  // ************************************************************
  logic [2:0] data_wr;
  logic [2:0] dir_wr;
  logic [WIDTH-1:0] latch   [3];
  logic [WIDTH-1:0] dir     [3];
  logic [WIDTH-1:0] eff_dir [3];
  logic [WIDTH-1:0] rd_val  [3];
  logic [WIDTH-1:0] force_c;
  logic [WIDTH-1:0] pins    [3];

  // Decode single-cycle writes to data and direction registers.
  always_comb
  begin
    data_wr = 3'h0;
    dir_wr  = 3'h0;
    if (wr_in && addr_in == `FPIO_ADDR_PORTA)
      data_wr[0] = 1'b1;
    else if (wr_in && addr_in == `FPIO_ADDR_PORTB)
      data_wr[1] = 1'b1;
    else if (wr_in && addr_in == `FPIO_ADDR_PORTC)
      data_wr[2] = 1'b1;
    else if (wr_in && addr_in == `FPIO_ADDR_DIRA)
      dir_wr[0] = 1'b1;
    else if (wr_in && addr_in == `FPIO_ADDR_DIRB)
      dir_wr[1] = 1'b1;
    else if (wr_in && addr_in == `FPIO_ADDR_DIRC)
      dir_wr[2] = 1'b1;
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  logic [3:0] clkctl_ff;
  logic [3:0] nxt_clkctl;
  fpio_byte_type adctl_ff;
  fpio_byte_type nxt_adctl;

  // Next control values; no stop or wait input touches them.
  always_comb
  begin
    nxt_clkctl = clkctl_ff;
    nxt_adctl  = adctl_ff;
    if (wr_in && addr_in == `FPIO_ADDR_CLKCTL)
      nxt_clkctl = wdata_in[3:0];
    if (wr_in && addr_in == `FPIO_ADDR_ADCTL)
      nxt_adctl = wdata_in & `FPIO_ADCTL_MASK;
  end

  // Both control registers clear on reset.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      clkctl_ff <= 4'h0;
      adctl_ff  <= `FPIO_RST_BYTE;
    end
    else
    begin
      clkctl_ff <= nxt_clkctl;
      adctl_ff  <= nxt_adctl;
    end
  end

  logic clk_en;
  assign clk_en = clkctl_ff[`FPIO_CLKOUT_BIT];

  // ************************************************************
  // Ports A, B and C
  // ************************************************************
  assign pins[0] = port_a_pin_in;
  assign pins[1] = port_b_pin_in;
  assign pins[2] = port_c_pin_in;

  // Clock output forces the direction of port C pin two only.
  always_comb
  begin
    force_c = '0;
    force_c[`FPIO_CLK_PIN] = clk_en;
  end

  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_port
      fpio_pin_slice #(.WIDTH(WIDTH)) u_slice (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .data_wr_in   (data_wr[p]),
        .dir_wr_in    (dir_wr[p]),
        .wdata_in     (wdata_in),
        .force_dir_in ((p == 2) ? force_c : '0),
        .pin_in       (pins[p]),
        .latch_out    (latch[p]),
        .dir_out      (dir[p]),
        .eff_dir_out  (eff_dir[p]),
        .rd_data_out  (rd_val[p])
      );
    end
  endgenerate

  // ************************************************************
  // Internal clock divider
  // ************************************************************
  logic [7:0] div_ff;
  logic [7:0] nxt_div;
  logic       phase_ff;
  logic       nxt_phase;

  // Divides the system clock to a phase clock by enable pulses.
  always_comb
  begin
    nxt_div   = div_ff + 8'h01;
    nxt_phase = phase_ff;
    if (div_ff == 8'(CLK_DIV - 1))
    begin
      nxt_div   = 8'h00;
      nxt_phase = ~phase_ff;
    end
  end

  // Divider state clears on reset.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_ff   <= 8'h00;
      phase_ff <= 1'b0;
    end
    else
    begin
      div_ff   <= nxt_div;
      phase_ff <= nxt_phase;
    end
  end

  // ************************************************************
  // Pin drive
  // ************************************************************
  fpio_byte_type    nxt_c_out;
  logic [WIDTH-1:0] nxt_force_c;

  // Port C pin two follows the clock-out bit from the very edge that changes it,
  // so the pin never drives a stale latch bit or lingers as an output.
  always_comb
  begin
    nxt_force_c                = '0;
    nxt_force_c[`FPIO_CLK_PIN] = nxt_clkctl[`FPIO_CLKOUT_BIT];
    nxt_c_out                  = data_wr[2] ? wdata_in : latch[2];
    if (nxt_force_c[`FPIO_CLK_PIN])
      nxt_c_out[`FPIO_CLK_PIN] = nxt_phase;
  end

  // Outputs registered; drive follows a write on the next edge.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      port_a_pin_out           <= `FPIO_LATCH_INIT;
      port_b_pin_out           <= `FPIO_LATCH_INIT;
      port_c_pin_out           <= `FPIO_LATCH_INIT;
      port_a_pin_oe_n_out      <= ~`FPIO_RST_BYTE;
      port_b_pin_oe_n_out      <= ~`FPIO_RST_BYTE;
      port_c_pin_oe_n_out      <= ~`FPIO_RST_BYTE;
      converter_on_out         <= 1'b0;
      internal_phase_clock_out <= 1'b0;
    end
    else
    begin
      port_a_pin_out           <= data_wr[0] ? wdata_in : latch[0];
      port_b_pin_out           <= data_wr[1] ? wdata_in : latch[1];
      port_c_pin_out           <= nxt_c_out;
      port_a_pin_oe_n_out      <= ~(dir_wr[0] ? wdata_in : dir[0]);
      port_b_pin_oe_n_out      <= ~(dir_wr[1] ? wdata_in : dir[1]);
      port_c_pin_oe_n_out      <= ~((dir_wr[2] ? wdata_in : dir[2]) | nxt_force_c);
      converter_on_out         <= nxt_adctl[`FPIO_CONV_ON_BIT];
      internal_phase_clock_out <= nxt_phase;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  fpio_byte_type nxt_rdata;

  // Read mux; unmapped addresses return zero.
  always_comb
  begin
    nxt_rdata = `FPIO_RST_BYTE;
    if (addr_in == `FPIO_ADDR_PORTA)
      nxt_rdata = rd_val[0];
    else if (addr_in == `FPIO_ADDR_PORTB)
      nxt_rdata = rd_val[1];
    else if (addr_in == `FPIO_ADDR_PORTC)
      nxt_rdata = rd_val[2];
    else if (addr_in == `FPIO_ADDR_PORTD)
      nxt_rdata = shared_input_pins_in;
    else if (addr_in == `FPIO_ADDR_DIRA)
      nxt_rdata = dir[0];
    else if (addr_in == `FPIO_ADDR_DIRB)
      nxt_rdata = dir[1];
    else if (addr_in == `FPIO_ADDR_DIRC)
      nxt_rdata = dir[2];
    else if (addr_in == `FPIO_ADDR_CLKCTL)
      nxt_rdata = {4'h0, clkctl_ff} & `FPIO_CLKCTL_MASK;
    else if (addr_in == `FPIO_ADDR_ADCTL)
      nxt_rdata = adctl_ff;
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= `FPIO_RST_BYTE;
    else
      rdata_out <= rd_in ? nxt_rdata : `FPIO_RST_BYTE;
  end
endmodule : fpio_top
`default_nettype wire

// ==== sim/fpio_pins_model.sv ====
/*
  Board model for one eight-bit bidirectional port: resolves each line.
  Assumes the board drives brd_in on every line the device leaves undriven.
*/
`timescale 1ns/100ps
`default_nettype none

module fpio_pins_model
(
  input  wire logic [7:0] oe_n_in,
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] brd_in,
  output logic      [7:0] pin_out
);
  // A line shows the device drive where enabled, else the board level.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_out[i] = oe_n_in[i] ? brd_in[i] : drv_in[i];
  end
endmodule : fpio_pins_model

`default_nettype wire

// ==== sim/fpio_top_assertions.sv ====
/*
  Concurrent checks on the ports of the four-port I/O block.
  Assumes it is bound to fpio_top from the bench top file.
*/
`timescale 1ns/100ps
`default_nettype none

module fpio_top_chk
  import fpio_pkg::*;
#(
  parameter int WIDTH   = 8,
  parameter int CLK_DIV = 2
)
(
  input wire logic                   sys_clk_in,
  input wire logic                   rst_n_in,
  input wire fpio_pkg::fpio_byte_type addr_in,
  input wire fpio_pkg::fpio_byte_type wdata_in,
  input wire logic                   wr_in,
  input wire logic                   rd_in,
  input wire fpio_pkg::fpio_byte_type rdata_out,
  input wire logic [WIDTH-1:0]       port_a_pin_in,
  input wire logic [WIDTH-1:0]       port_a_pin_out,
  input wire logic [WIDTH-1:0]       port_a_pin_oe_n_out,
  input wire logic [WIDTH-1:0]       port_b_pin_out,
  input wire logic [WIDTH-1:0]       port_b_pin_oe_n_out,
  input wire logic [WIDTH-1:0]       port_c_pin_oe_n_out,
  input wire logic [WIDTH-1:0]       shared_input_pins_in,
  input wire logic                   converter_on_out
);
  // All checks run on the one clock and stop while reset is low.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  dir_reset_a: assert property ($rose(rst_n_in) |->
    &{port_a_pin_oe_n_out, port_b_pin_oe_n_out, port_c_pin_oe_n_out}) else $error("pins not inputs");
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  unmapped_zero_a: assert property (rd_in && (addr_in == 8'h08 || addr_in > 8'h09)
    |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  clkctl_upper_a: assert property (rd_in && addr_in == 8'h07 |=> rdata_out[7:4] == 4'h0)
    else $error("clock control upper bits set");
  dir_drive_a: assert property (wr_in && addr_in == 8'h04
    |=> port_a_pin_oe_n_out == ~$past(wdata_in)) else $error("direction not applied");
  data_drive_a: assert property (wr_in && addr_in == 8'h01
    |=> ((port_b_pin_out ^ $past(wdata_in)) & ~port_b_pin_oe_n_out) == 8'h00)
    else $error("output data not driven");
  read_mix_a: assert property (rd_in && addr_in == 8'h00 |=> rdata_out ==
    (($past(port_a_pin_out) & ~$past(port_a_pin_oe_n_out)) |
     ($past(port_a_pin_in) & $past(port_a_pin_oe_n_out)))) else $error("port read wrong");
  shared_read_a: assert property (rd_in && addr_in == 8'h03
    |=> rdata_out == $past(shared_input_pins_in)) else $error("input port read wrong");
  conv_bit_a: assert property (wr_in && addr_in == 8'h09
    |=> converter_on_out == $past(wdata_in[5])) else $error("converter bit wrong");
  clk_pin_a: assert property (wr_in && addr_in == 8'h07 && wdata_in[3]
    |=> !port_c_pin_oe_n_out[2]) else $error("clock pin not driven");
endmodule : fpio_top_chk

`default_nettype wire

// ==== sim/fpio_top_test.sv ====
/*
  Self-checking bench for the four-port I/O block with board pin models.
  Assumes the pin model and the checker are compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpio_regs.svh"
`define CHK(n, e, g) chk(n, e, g)

module fpio_top_test;
  import fpio_pkg::*;
  logic          clk        = 1'b0;
  logic          rst_n      = 1'b0;
  fpio_byte_type addr       = 8'h00;
  fpio_byte_type wdata      = 8'h00;
  logic          wr         = 1'b0;
  logic          rd         = 1'b0;
  fpio_byte_type rdata;
  logic [7:0]    brd [3]    = '{default: 8'h00};
  logic [7:0]    pin [3];
  logic [7:0]    pout [3];
  logic [7:0]    oe_n [3];
  logic [7:0]    shd        = 8'h00;
  logic          conv;
  logic          phs;
  int            fail_count = 0;
  int            cmp_count  = 0;

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  fpio_top i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .port_a_pin_in(pin[0]),
    .port_a_pin_out(pout[0]), .port_a_pin_oe_n_out(oe_n[0]), .port_b_pin_in(pin[1]),
    .port_b_pin_out(pout[1]), .port_b_pin_oe_n_out(oe_n[1]), .port_c_pin_in(pin[2]),
    .port_c_pin_out(pout[2]), .port_c_pin_oe_n_out(oe_n[2]), .shared_input_pins_in(shd),
    .converter_on_out(conv), .internal_phase_clock_out(phs));

  // One board model per bidirectional port.
  for (genvar g = 0; g < 3; g++)
  begin : g_pm
    fpio_pins_model i_pm (.oe_n_in(oe_n[g]), .drv_in(pout[g]), .brd_in(brd[g]),
      .pin_out(pin[g]));
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic reset_dut;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
  endtask : reset_dut

  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : bw

  task automatic br(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : br

  task automatic t_reset;
    logic [7:0] d;
    for (int p = 0; p < 3; p++)
    begin
      br(8'h04 + 8'(p), d);
      `CHK("dir", 8'h00, d);
      `CHK("oe_n", 8'hff, oe_n[p]);
    end
    br(`FPIO_ADDR_CLKCTL, d);
    `CHK("clkctl", 8'h00, d);
    br(`FPIO_ADDR_ADCTL, d);
    `CHK("adctl", 8'h00, d);
    `CHK("conv rst", 8'h00, {7'h00, conv});
  endtask : t_reset

  task automatic t_ports;
    logic [7:0] d;
    for (int p = 0; p < 3; p++)
    begin
      @(posedge clk);
      brd[p] <= 8'h3c;
      bw(8'(p), 8'ha5);
      `CHK("in oe_n", 8'hff, oe_n[p]);
      br(8'(p), d);
      `CHK("in rd", 8'h3c, d);
      bw(8'h04 + 8'(p), 8'hf0);
      `CHK("oe_n", 8'h0f, oe_n[p]);
      `CHK("drv", 8'ha0, pout[p] & 8'hf0);
      br(8'(p), d);
      `CHK("mix rd", 8'hac, d);
      bw(8'(p), 8'h5a);
      `CHK("drv now", 8'h50, pout[p] & 8'hf0);
      br(8'h04 + 8'(p), d);
      `CHK("dir rd", 8'hf0, d);
    end
  endtask : t_ports

  task automatic t_latch;
    bw(`FPIO_ADDR_PORTA, 8'h5a);
    reset_dut;
    `CHK("rst oe_n", 8'hff, oe_n[0]);
    bw(`FPIO_ADDR_DIRA, 8'hff);
    `CHK("kept", 8'h5a, pout[0]);
  endtask : t_latch

  task automatic t_clock_out;
    logic [7:0] d;
    logic       v;
    int         n;
    @(posedge clk);
    brd[2] <= 8'hff;
    bw(`FPIO_ADDR_PORTC, 8'h00);
    bw(`FPIO_ADDR_DIRC, 8'h00);
    bw(`FPIO_ADDR_CLKCTL, 8'hff);
    br(`FPIO_ADDR_CLKCTL, d);
    `CHK("clkctl", 8'h0f, d);
    `CHK("c oe_n", 8'hfb, oe_n[2]);
    br(`FPIO_ADDR_PORTC, d);
    `CHK("c rd", 8'hfb, d);
    // Count clock pin edges over a fixed window; half period is two cycles.
    n = 0;
    v = pout[2][2];
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      `CHK("clk pin", {7'h00, phs}, {7'h00, pout[2][2]});
      n = n + int'(pout[2][2] !== v);
      v = pout[2][2];
    end
    `CHK("toggles", 8'h14, 8'(n));
    bw(`FPIO_ADDR_CLKCTL, 8'h00);
    `CHK("c oe off", 8'hff, oe_n[2]);
    br(`FPIO_ADDR_PORTC, d);
    `CHK("c rd off", 8'hff, d);
  endtask : t_clock_out

  task automatic t_port_d;
    logic [7:0] d;
    @(posedge clk);
    shd <= 8'h96;
    bw(`FPIO_ADDR_ADCTL, 8'h20);
    `CHK("conv on", 8'h01, {7'h00, conv});
    br(`FPIO_ADDR_ADCTL, d);
    `CHK("adctl rd", 8'h20, d);
    bw(`FPIO_ADDR_PORTD, 8'h00);
    br(`FPIO_ADDR_PORTD, d);
    `CHK("pd rd", 8'h96, d);
    br(8'h08, d);
    `CHK("gap rd", 8'h00, d);
    br(8'h0a, d);
    `CHK("high rd", 8'h00, d);
    bw(`FPIO_ADDR_ADCTL, 8'h00);
    `CHK("conv off", 8'h00, {7'h00, conv});
  endtask : t_port_d

  task automatic conclude;
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Main sequence.
  initial
  begin
    reset_dut;
    t_reset;
    t_ports;
    t_latch;
    t_clock_out;
    t_port_d;
    conclude;
  end
endmodule : fpio_top_test

bind fpio_top fpio_top_chk #(.WIDTH(WIDTH), .CLK_DIV(CLK_DIV)) i_chk (
  .sys_clk_in           (sys_clk_in),
  .rst_n_in             (rst_n_in),
  .addr_in              (addr_in),
  .wdata_in             (wdata_in),
  .wr_in                (wr_in),
  .rd_in                (rd_in),
  .rdata_out            (rdata_out),
  .port_a_pin_in        (port_a_pin_in),
  .port_a_pin_out       (port_a_pin_out),
  .port_a_pin_oe_n_out  (port_a_pin_oe_n_out),
  .port_b_pin_out       (port_b_pin_out),
  .port_b_pin_oe_n_out  (port_b_pin_oe_n_out),
  .port_c_pin_oe_n_out  (port_c_pin_oe_n_out),
  .shared_input_pins_in (shared_input_pins_in),
  .converter_on_out     (converter_on_out)
);

`default_nettype wire
